// >>> mult_pkg.sv
// shared constants and types for the serial booth multiplier pair
package mult_pkg;
   localparam int X_WIDTH = 8;
   localparam int Y_WIDTH = 8;
   localparam int PROD_WIDTH = X_WIDTH + Y_WIDTH;
   localparam int STEP_COUNT = X_WIDTH + Y_WIDTH;
   localparam logic [4:0] STEP_LAST = 5'h0F;
   localparam logic [4:0] STEP_ZERO = 5'h00;
   localparam logic [X_WIDTH-1:0] X_RESET = 8'h00;
   localparam logic [1:0] CARRY0_RESET = 2'h0;
   localparam logic [PROD_WIDTH-1:0] PROD_RESET = 16'h0000;
   // apb map
   localparam logic [7:0] OPERAND_OFFSET = 8'h00;
   localparam logic [7:0] CONTROL_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] RESULT_OFFSET = 8'h0C;
   localparam int OPERAND_X_LSB = 0;
   localparam int OPERAND_Y_LSB = 8;
   localparam int CONTROL_START_BIT = 0;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_VALID_BIT = 1;
   localparam int STATUS_FULL_BIT = 2;
   localparam int BUF_DEPTH = 2;
   localparam logic [1:0] BUF_FULL_COUNT = 2'h2;
   typedef enum logic [2:0] {
      OP_SHIFT = 3'b001,
      OP_ADD = 3'b010,
      OP_SUB = 3'b100
   } booth_op_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_LOAD = 5'b00010,
      ST_RUN = 5'b00100,
      ST_DRAIN = 5'b01000,
      ST_PUSH = 5'b10000
   } ctrl_state_t;
endpackage

// >>> mult_link_if.sv
// link between the multiplier slice and its sequencing controller
`timescale 1ns/10ps
interface mult_link_if;
   import mult_pkg::*;
   logic clear_n_latch_open;
   logic step;
   logic [X_WIDTH-1:0] x_operand;
   logic y_serial;
   logic k_expand;
   logic mode;
   logic s_serial;
   modport slice (
      input clear_n_latch_open,
      input step,
      input x_operand,
      input y_serial,
      input k_expand,
      input mode,
      output s_serial
   );
   modport ctrl (
      output clear_n_latch_open,
      output step,
      output x_operand,
      output y_serial,
      output k_expand,
      output mode,
      input s_serial
   );
endinterface

// >>> mult_slice.sv
// 8-bit by 1-bit serial/parallel booth multiplier slice
`timescale 1ns/10ps
module mult_slice
   import mult_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // link to controller and neighbours
   mult_link_if.slice link,
   // observation
   output logic [X_WIDTH-1:0] x_held_out,
   output logic [2:0] last_op_out,
   output logic busy_out
);

   logic [X_WIDTH-1:0] x_reg;
   logic [X_WIDTH-1:0] x_next;
   logic [X_WIDTH-1:0] sum_reg;
   logic [X_WIDTH-1:0] sum_next;
   logic [X_WIDTH-1:1] carry_reg;
   logic [X_WIDTH-1:1] carry_next;
   logic [1:0] carry0_reg;
   logic [1:0] carry0_next;
   logic y_prev_reg;
   logic y_prev_next;
   logic s_reg;
   logic s_next;
   booth_op_t op_reg;
   booth_op_t op_next;
   logic stepped_reg;
   logic stepped_next;

   booth_op_t op;
   logic [X_WIDTH-1:0] pp;
   logic [X_WIDTH-1:0] cell_sum;
   logic [X_WIDTH-1:1] cell_carry;
   logic [2:0] cell0_total;
   logic top_in;

   // booth pair decode
   always_comb begin
      unique case ({link.y_serial, y_prev_reg})
         2'b01: op = OP_ADD;
         2'b10: op = OP_SUB;
         default: op = OP_SHIFT;
      endcase
   end

   // partial product per bit; subtract uses inverted bits plus one at cell 0
   always_comb begin
      unique case (op)
         OP_ADD: pp = x_reg;
         OP_SUB: pp = ~x_reg;
         default: pp = X_RESET;
      endcase
   end

   // upper carry-save cells keep their own carry in place while sums move down
   genvar gi;
   generate
      for (gi = 1; gi < X_WIDTH; gi = gi + 1) begin : g_cell
         logic [1:0] total;
         assign total = {1'b0, sum_reg[gi]} + {1'b0, pp[gi]} + {1'b0, carry_reg[gi]};
         assign cell_sum[gi] = total[0];
         assign cell_carry[gi] = total[1];
      end
   endgenerate

   // lowest cell also takes the +1 of a subtract, so its carry is two bits
   always_comb begin
      cell0_total = {2'b00, sum_reg[0]} + {2'b00, pp[0]} + {1'b0, carry0_reg}
         + {2'b00, (op == OP_SUB)};
      cell_sum[0] = cell0_total[0];
   end

   // top slice sign-extends itself; lower slices take the higher product bit
   always_comb begin
      top_in = link.mode ? link.k_expand : cell_sum[X_WIDTH-1];
   end

   // next state of the whole slice
   always_comb begin
      x_next = x_reg;
      sum_next = sum_reg;
      carry_next = carry_reg;
      carry0_next = carry0_reg;
      y_prev_next = y_prev_reg;
      s_next = s_reg;
      op_next = op_reg;
      stepped_next = 1'b0;
      if (!link.clear_n_latch_open) begin
         // latches open and every flop cleared; steps ignored
         x_next = link.x_operand;
         sum_next = X_RESET;
         carry_next = '0;
         carry0_next = CARRY0_RESET;
         y_prev_next = 1'b0;
         s_next = 1'b0;
         op_next = OP_SHIFT;
      end else if (link.step) begin
         // x_next kept: latches closed while clear is high
         sum_next = {top_in, cell_sum[X_WIDTH-1:1]};
         carry_next = cell_carry;
         carry0_next = cell0_total[2:1];
         y_prev_next = link.y_serial;
         s_next = cell_sum[0];
         op_next = op;
         stepped_next = 1'b1;
      end
   end

   // all state moves on the rising edge
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         x_reg <= X_RESET;
         sum_reg <= X_RESET;
         carry_reg <= '0;
         carry0_reg <= CARRY0_RESET;
         y_prev_reg <= 1'b0;
         s_reg <= 1'b0;
         op_reg <= OP_SHIFT;
         stepped_reg <= 1'b0;
      end else begin
         x_reg <= x_next;
         sum_reg <= sum_next;
         carry_reg <= carry_next;
         carry0_reg <= carry0_next;
         y_prev_reg <= y_prev_next;
         s_reg <= s_next;
         op_reg <= op_next;
         stepped_reg <= stepped_next;
      end
   end

   // outputs straight from flops
   assign link.s_serial = s_reg;
   assign x_held_out = x_reg;
   assign last_op_out = op_reg;
   assign busy_out = stepped_reg;

endmodule

// >>> mult_controller.sv
// apb-driven sequencing controller for one multiplier slice
`timescale 1ns/10ps
module mult_controller
   import mult_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link to the slice
   mult_link_if.ctrl link
);

   ctrl_state_t state_reg;
   ctrl_state_t state_next;
   logic [X_WIDTH-1:0] x_reg;
   logic [X_WIDTH-1:0] x_next;
   logic [Y_WIDTH-1:0] y_reg;
   logic [Y_WIDTH-1:0] y_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic step_reg;
   logic step_next;
   logic cap_reg;
   logic cap_next;
   logic ybit_reg;
   logic ybit_next;
   logic clr_n_reg;
   logic clr_n_next;
   logic [PROD_WIDTH-1:0] prod_reg;
   logic [PROD_WIDTH-1:0] prod_next;

   logic [PROD_WIDTH-1:0] buf_mem [BUF_DEPTH];
   logic wr_ptr_reg;
   logic wr_ptr_next;
   logic rd_ptr_reg;
   logic rd_ptr_next;
   logic [1:0] count_reg;
   logic [1:0] count_next;

   logic access;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic in_valid;
   logic in_ready;
   logic out_valid;
   logic out_ready;

   // zero-wait slave: every access completes in its first access cycle
   assign access = psel && penable;
   assign wr_en = access && pwrite;
   assign rd_en = access && !pwrite;
   assign mapped = (paddr == OPERAND_OFFSET) || (paddr == CONTROL_OFFSET) ||
                   (paddr == STATUS_OFFSET) || (paddr == RESULT_OFFSET);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   // two-entry result buffer handshakes
   assign in_valid = (state_reg == ST_PUSH);
   assign in_ready = (count_reg != BUF_FULL_COUNT);
   assign out_valid = (count_reg != 2'h0);
   assign out_ready = rd_en && (paddr == RESULT_OFFSET);

   always_comb begin
      prdata = 32'h00000000;
      if (rd_en) begin
         unique case (paddr)
            OPERAND_OFFSET: begin
               prdata[OPERAND_X_LSB +: X_WIDTH] = x_reg;
               prdata[OPERAND_Y_LSB +: Y_WIDTH] = y_reg;
            end
            STATUS_OFFSET: begin
               prdata[STATUS_BUSY_BIT] = (state_reg != ST_IDLE);
               prdata[STATUS_VALID_BIT] = out_valid;
               prdata[STATUS_FULL_BIT] = !in_ready;
            end
            RESULT_OFFSET: prdata[PROD_WIDTH-1:0] = out_valid ? buf_mem[rd_ptr_reg] : PROD_RESET;
            default: prdata = 32'h00000000;
         endcase
      end
   end

   // sequencer
   always_comb begin
      state_next = state_reg;
      x_next = x_reg;
      y_next = y_reg;
      cnt_next = cnt_reg;
      step_next = 1'b0;
      cap_next = step_reg;
      ybit_next = ybit_reg;
      clr_n_next = 1'b1;
      prod_next = prod_reg;
      if (cap_reg) begin
         // product leaves lsb first, so bits enter from the top
         prod_next = {link.s_serial, prod_reg[PROD_WIDTH-1:1]};
      end
      // operands are locked while a product is in flight
      if (wr_en && (paddr == OPERAND_OFFSET) && (state_reg == ST_IDLE)) begin
         x_next = pwdata[OPERAND_X_LSB +: X_WIDTH];
         y_next = pwdata[OPERAND_Y_LSB +: Y_WIDTH];
      end
      unique case (state_reg)
         ST_IDLE: begin
            if (wr_en && (paddr == CONTROL_OFFSET) && pwdata[CONTROL_START_BIT]) begin
               state_next = ST_LOAD;
               clr_n_next = 1'b0;
            end
         end
         ST_LOAD: begin
            cnt_next = STEP_ZERO;
            prod_next = PROD_RESET;
            state_next = ST_RUN;
         end
         ST_RUN: begin
            step_next = 1'b1;
            // lsb first, then the sign bit again
            ybit_next = (cnt_reg < 5'(Y_WIDTH)) ? y_reg[cnt_reg[2:0]] : y_reg[Y_WIDTH-1];
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == STEP_LAST) begin
               state_next = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!step_reg && !cap_reg) begin
               state_next = ST_PUSH;
            end
         end
         ST_PUSH: begin
            // waits here while the buffer is full, so no product is dropped
            if (in_ready) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= ST_IDLE;
         x_reg <= X_RESET;
         y_reg <= X_RESET;
         cnt_reg <= STEP_ZERO;
         step_reg <= 1'b0;
         cap_reg <= 1'b0;
         ybit_reg <= 1'b0;
         clr_n_reg <= 1'b1;
         prod_reg <= PROD_RESET;
      end else begin
         state_reg <= state_next;
         x_reg <= x_next;
         y_reg <= y_next;
         cnt_reg <= cnt_next;
         step_reg <= step_next;
         cap_reg <= cap_next;
         ybit_reg <= ybit_next;
         clr_n_reg <= clr_n_next;
         prod_reg <= prod_next;
      end
   end

   // buffer pointers
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (in_valid && in_ready) begin
         wr_ptr_next = !wr_ptr_reg;
      end
      if (out_valid && out_ready) begin
         rd_ptr_next = !rd_ptr_reg;
      end
      count_next = count_reg + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (in_valid && in_ready) begin
         buf_mem[wr_ptr_reg] <= prod_reg;
      end
   end

   // single slice is the top slice: k and mode low
   assign link.k_expand = 1'b0;
   assign link.mode = 1'b0;
   assign link.clear_n_latch_open = clr_n_reg;
   assign link.x_operand = x_reg;
   assign link.step = step_reg;
   assign link.y_serial = ybit_reg;

endmodule

// >>> mult_props.sv
// assertion checker for the slice link
`timescale 1ns/10ps
module mult_props
   import mult_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // link signals
   input wire logic clear_n_latch_open,
   input wire logic step,
   input wire logic [X_WIDTH-1:0] x_operand,
   input wire logic y_serial,
   input wire logic k_expand,
   input wire logic mode,
   input wire logic s_serial
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   logic [4:0] cnt_reg;
   logic [15:0] y_reg;
   logic [7:0] x_reg;
   logic bit_reg;
   logic sign_reg;
   // low product bits need no multiplier bits above them
   wire logic [15:0] y_now = y_reg | (16'(y_serial) << cnt_reg);
   wire logic [15:0] prod_now = {{8{x_reg[7]}}, x_reg} * y_now;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg <= 5'h00;
         y_reg <= 16'h0000;
         x_reg <= 8'h00;
         bit_reg <= 1'b0;
         sign_reg <= 1'b0;
      end else if (!clear_n_latch_open) begin
         cnt_reg <= 5'h00;
         y_reg <= 16'h0000;
         x_reg <= x_operand;
      end else if (step) begin
         cnt_reg <= cnt_reg + 5'h01;
         y_reg <= y_now;
         bit_reg <= prod_now[cnt_reg[3:0]];
         if (cnt_reg == 5'h07) begin
            sign_reg <= y_serial;
         end
      end
   end
   a_clear_zeroes_out: assert property (!clear_n_latch_open |=> !s_serial)
      else $error("product bit not cleared");
   a_clear_one_cycle: assert property ($fell(clear_n_latch_open) |=> clear_n_latch_open)
      else $error("clear held beyond one cycle");
   a_no_step_clear: assert property (!clear_n_latch_open |-> !step)
      else $error("step during clear");
   a_out_holds_idle: assert property (clear_n_latch_open && !step |=> $stable(s_serial))
      else $error("product bit moved without step");
   a_product_bit: assert property (step |=> s_serial == bit_reg)
      else $error("wrong product bit");
   a_sign_repeat: assert property (step && cnt_reg >= 5'h08 |-> y_serial == sign_reg)
      else $error("multiplier sign not repeated");
   a_step_limit: assert property (step |-> cnt_reg < 5'h10)
      else $error("more than sixteen steps");
   a_top_slice_tie: assert property (!k_expand && !mode)
      else $error("top slice inputs not low");
endmodule

// >>> serial_parallel_booth_multiplier_bench.sv
// self-checking bench for the multiplier pair over apb
`timescale 1ns/10ps
module serial_parallel_booth_multiplier_bench
   import mult_pkg::*;
;
   logic clk_in;
   logic nrst_in;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [X_WIDTH-1:0] x_held;
   logic [2:0] last_op;
   logic slice_busy;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int samples_checked = 0;
   // step pulses seen by the slice, counted per run
   int steps_seen = 0;
   int base_steps = 0;
   // multiplicand of the last started run; the slice must keep it until the next clear
   logic [7:0] last_x = 8'h00;
   logic [7:0] xs [6] = '{8'h03, 8'h80, 8'h7F, 8'hFF, 8'h00, 8'hFD};
   logic [7:0] ys [6] = '{8'h05, 8'h80, 8'h80, 8'h01, 8'hF9, 8'hAB};
   mult_link_if link_bus ();
   mult_slice i_mult_slice (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_bus.slice), .x_held_out(x_held),
      .last_op_out(last_op), .busy_out(slice_busy));
   mult_controller i_mult_controller (.clk_in(clk_in), .nrst_in(nrst_in), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link_bus.ctrl));
   mult_props i_mult_props (.clk_in(clk_in), .nrst_in(nrst_in), .clear_n_latch_open(link_bus.clear_n_latch_open),
      .step(link_bus.step), .x_operand(link_bus.x_operand), .y_serial(link_bus.y_serial),
      .k_expand(link_bus.k_expand), .mode(link_bus.mode), .s_serial(link_bus.s_serial));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (slice_busy === 1'b1) begin
         steps_seen <= steps_seen + 1;
      end
   end
   task automatic wrap_up();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      // pready is tied high, so this wait ends on the first edge
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   function automatic logic [31:0] prod(input logic [7:0] x, input logic [7:0] y);
      logic [15:0] p;
      p = {{8{x[7]}}, x} * {{8{y[7]}}, y};
      return {16'h0000, p};
   endfunction
   task automatic go(input logic [7:0] x, input logic [7:0] y);
      apb(1'b1, OPERAND_OFFSET, {16'h0000, y, x});
      rchk(OPERAND_OFFSET, {16'h0000, y, x}, "operand");
      // new operand has stood on the link for several edges with clear high
      chk("closed latch", {24'h0, last_x}, {24'h0, x_held});
      apb(1'b1, CONTROL_OFFSET, 32'h1);
      last_x = x;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFFSET, 32'h0);
         n++;
      end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 40);
      chk("busy", 32'h0, {31'h0, rd[STATUS_BUSY_BIT]});
   endtask
   initial begin
      nrst_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      rchk(STATUS_OFFSET, 32'h0, "status");
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      for (int i = 0; i < 6; i++) begin
         base_steps = steps_seen;
         go(xs[i], ys[i]);
         wait_idle();
         chk("step count", STEP_COUNT, steps_seen - base_steps);
         // last step repeats the sign bit, so both bits match
         chk("last op", {29'h0, OP_SHIFT}, {29'h0, last_op});
         chk("held operand", {24'h0, xs[i]}, {24'h0, x_held});
         rchk(RESULT_OFFSET, prod(xs[i], ys[i]), "product");
      end
      // two results fill the buffer, the third run stalls until a pop
      go(8'h12, 8'h34);
      wait_idle();
      go(8'h9C, 8'h07);
      wait_idle();
      rchk(STATUS_OFFSET, 32'h6, "status full");
      go(8'hC8, 8'hE3);
      repeat (40) @(posedge clk_in);
      apb(1'b1, OPERAND_OFFSET, 32'h5555);
      chk("latched operand", 32'hC8, {24'h0, x_held});
      rchk(OPERAND_OFFSET, 32'h0000E3C8, "locked operand");
      rchk(STATUS_OFFSET, 32'h7, "status stalled");
      rchk(RESULT_OFFSET, prod(8'h12, 8'h34), "first result");
      wait_idle();
      rchk(RESULT_OFFSET, prod(8'h9C, 8'h07), "second result");
      rchk(RESULT_OFFSET, prod(8'hC8, 8'hE3), "third result");
      rchk(RESULT_OFFSET, 32'h0, "empty result");
      rchk(STATUS_OFFSET, 32'h0, "status empty");
      rchk(CONTROL_OFFSET, 32'h0, "control read");
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      wrap_up();
   end
endmodule
